// ---- include/sync_serial_pkg.sv ----
// Constants, register map and types shared by the synchronous serial unit
package sync_serial_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_RX_DATA   = 8'h08;
  localparam logic [7:0] OFF_TX_DATA   = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;

  // ==========================================================================
  // Control register fields
  localparam int         CTRL_W        = 6;
  localparam int         BIT_PORT_EN   = 0;
  localparam int         BIT_RX_EN     = 1;
  localparam int         BIT_NINTH_EN  = 2;
  localparam int         BIT_SLAVE     = 3;
  localparam int         BIT_SLEEP     = 4;
  localparam int         BIT_TX_NINTH  = 5;
  localparam logic [5:0] CTRL_RESET    = 6'h00;

  // ==========================================================================
  // Status register fields
  localparam int         ST_RX_FLAG    = 0;
  localparam int         ST_TX_FLAG    = 1;
  localparam int         ST_OVERRUN    = 2;
  localparam int         ST_RX_NINTH   = 3;
  localparam int         ST_TSR_EMPTY  = 4;
  localparam int         ST_FIFO_LVL   = 5;

  // ==========================================================================
  // Interrupt status and mask fields
  localparam int         EV_W          = 3;
  localparam int         EV_RX         = 0;
  localparam int         EV_TX         = 1;
  localparam int         EV_OVR        = 2;
  localparam logic [2:0] MASK_RESET    = 3'h0;

  // ==========================================================================
  // Character and buffer sizes
  localparam int         BYTE_W        = 8;
  localparam int         CHAR_W        = 9;
  localparam logic [3:0] LEN_SHORT     = 4'h8;
  localparam logic [3:0] LEN_LONG      = 4'h9;
  localparam logic [1:0] FIFO_FULL     = 2'h2;
  localparam logic       TX_FLAG_RESET = 1'b1;

  // ==========================================================================
  // Bus answers and handshake states
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    AX_IDLE = 3'b001,
    AX_BRSP = 3'b010,
    AX_RRSP = 3'b100
  } bus_state_t;

endpackage

// ---- core/sync_serial_rx_tx_sleep.sv ----
// Synchronous slave serial transceiver with receive FIFO and AXI4-Lite registers
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
// Function
// - Setting the ninth-bit enable makes characters nine bits long instead of eight.
// - Characters are received only while continuous receive enable is set.
// - A completed character sets the receive flag and, if enabled, an interrupt.
// - In nine-bit mode the top received bit shows in the received-ninth-bit field.
// - Reading the receive data register returns the low byte of the oldest character.
// - Overrun clears when receive enable or port enable drops; port enable resets the unit.
// - Only synchronous slave mode keeps shifting; clock-dependent modes stop.
// - In slave mode the outside party supplies the clock that runs both shift registers.
// - Reading receive data unloads a character and the flag drops once the FIFO is empty.
// - In slave reception the master drives data and clock and data is sampled by that clock.
// - A word clocked in sets the receive flag, which wakes the processor from sleep; here wake also needs the receive interrupt unmasked.
// - In slave transmission the device takes the pin clock and drives the data pin.
// - Writes into an empty transmitter fill the shift register then the buffer.
// - When the shift register empties the buffered byte moves in and the transmit flag sets.
// - A transmit data write clears the transmit flag only while the buffer is empty; a write into a full buffer is ignored.
module sync_serial_rx_tx_sleep
  import sync_serial_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [31:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_n,
  output logic             irq,
  output logic             wake
);
  import sync_serial_pkg::*;

  // ==========================================================================
  // State record
  typedef struct packed {
    bus_state_t             bus;
    logic                   have_aw;
    logic [7:0]             aw_addr;
    logic                   have_w;
    logic [31:0]            w_data;
    logic                   w_lane0;
    logic [1:0]             bresp;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [CTRL_W-1:0]      ctrl;
    logic [EV_W-1:0]        irq_stat;
    logic [EV_W-1:0]        irq_mask;
    logic [2:0]             ck_sync;
    logic                   ck_level;
    logic [2:0]             dt_sync;
    logic                   dt_level;
    logic [1:0][CHAR_W-1:0] fifo;
    logic                   rd_ptr;
    logic [1:0]             fifo_cnt;
    logic                   overrun;
    logic [CHAR_W-1:0]      rsr;
    logic [3:0]             rx_cnt;
    logic [CHAR_W-1:0]      tx_buf;
    logic                   buf_full;
    logic [CHAR_W-1:0]      transmit_shift_reg;
    logic                   tsr_full;
    logic [3:0]             tx_cnt;
    logic                   tx_flag;
    logic                   data_out;
  } state_t;

  state_t            q;
  state_t            n;
  logic              ck_stable;
  logic              ck_rise;
  logic              ck_fall;
  logic              shift_on;
  logic              rx_push;
  logic [CHAR_W-1:0] rx_char;
  logic              pop;
  logic              ovr;
  logic              tx_wr;
  logic [EV_W-1:0]   ev;
  logic [EV_W-1:0]   w1c;

  // Character length in shift clocks
  function automatic logic [3:0] char_len(input logic ninth);
    return ninth ? LEN_LONG : LEN_SHORT;
  endfunction

  // Read-back value of a register
  function automatic logic [31:0] reg_value(input state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      OFF_CTRL:     v[CTRL_W-1:0] = s.ctrl;
      OFF_STATUS: begin
        v[ST_RX_FLAG]   = (s.fifo_cnt != 2'h0);
        v[ST_TX_FLAG]   = s.tx_flag;
        v[ST_OVERRUN]   = s.overrun;
        v[ST_RX_NINTH]  = s.fifo[s.rd_ptr][BYTE_W];
        v[ST_TSR_EMPTY] = !s.tsr_full;
        v[ST_FIFO_LVL+:2] = s.fifo_cnt;
      end
      OFF_RX_DATA:  v[BYTE_W-1:0] = (s.fifo_cnt != 2'h0) ? s.fifo[s.rd_ptr][BYTE_W-1:0] : 8'h00;
      OFF_IRQ_STAT: v[EV_W-1:0] = s.irq_stat;
      OFF_IRQ_MASK: v[EV_W-1:0] = s.irq_mask;
      default:      v = 32'h0;
    endcase
    return v;
  endfunction

  // Address decode
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_RX_DATA) ||
           (a == OFF_TX_DATA) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction

  // ==========================================================================
  // Handshake outputs
  assign awready = (q.bus == AX_IDLE) && !q.have_aw;
  assign wready  = (q.bus == AX_IDLE) && !q.have_w;
  assign arready = (q.bus == AX_IDLE) && !q.have_aw && !q.have_w;
  assign bvalid  = (q.bus == AX_BRSP);
  assign rvalid  = (q.bus == AX_RRSP);
  assign bresp   = q.bresp;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  // Pin and interrupt outputs
  assign serial_data_out  = q.data_out;
  assign serial_data_oe_n = !(shift_on && !q.ctrl[BIT_RX_EN] && q.tsr_full);
  assign irq  = |(q.irq_stat & q.irq_mask);
  assign wake = q.ctrl[BIT_SLEEP] && irq;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    n       = q;
    rx_push = 1'b0;
    rx_char = '0;
    pop     = 1'b0;
    ovr     = 1'b0;
    tx_wr   = 1'b0;
    ev      = '0;
    w1c     = '0;

    // Pin synchronisers, level accepted once stages two and three agree
    n.ck_sync = {q.ck_sync[1:0], serial_clock_pin};
    n.dt_sync = {q.dt_sync[1:0], serial_data_in};
    ck_stable = (q.ck_sync[1] == q.ck_sync[2]);
    ck_rise   = ck_stable && q.ck_sync[2] && !q.ck_level;
    ck_fall   = ck_stable && !q.ck_sync[2] && q.ck_level;
    if (ck_stable) begin
      n.ck_level = q.ck_sync[2];
    end
    if (q.dt_sync[1] == q.dt_sync[2]) begin
      n.dt_level = q.dt_sync[2];
    end

    // Only slave mode runs off the pin clock; no internal clock mode shifts
    shift_on = q.ctrl[BIT_PORT_EN] && q.ctrl[BIT_SLAVE];

    // Bus side: address and data taken in either order
    case (q.bus)
      AX_IDLE: begin
        if (awvalid && awready) begin
          n.have_aw = 1'b1;
          n.aw_addr = awaddr[7:0];
        end
        if (wvalid && wready) begin
          n.have_w  = 1'b1;
          n.w_data  = wdata;
          n.w_lane0 = wstrb[0];
        end
        if (q.have_aw && q.have_w) begin
          n.have_aw = 1'b0;
          n.have_w  = 1'b0;
          n.bus     = AX_BRSP;
          n.bresp   = (mapped(q.aw_addr) && (q.aw_addr[1:0] == 2'h0)) ? RESP_OKAY : RESP_SLVERR;
          if (q.w_lane0) begin
            case (q.aw_addr)
              OFF_CTRL:     n.ctrl     = q.w_data[CTRL_W-1:0];
              OFF_IRQ_STAT: w1c        = q.w_data[EV_W-1:0];
              OFF_IRQ_MASK: n.irq_mask = q.w_data[EV_W-1:0];
              OFF_TX_DATA:  tx_wr      = 1'b1;
              default:      n.bresp    = q.aw_addr[1:0] == 2'h0 && mapped(q.aw_addr) ?
                                         RESP_OKAY : RESP_SLVERR;
            endcase
          end
        end else if (arvalid && arready) begin
          n.bus   = AX_RRSP;
          n.rdata = reg_value(q, araddr[7:0]);
          n.rresp = mapped(araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
          pop     = (araddr[7:0] == OFF_RX_DATA) && (q.fifo_cnt != 2'h0);
        end
      end
      AX_BRSP: begin
        if (bready) begin
          n.bus = AX_IDLE;
        end
      end
      AX_RRSP: begin
        if (rready) begin
          n.bus = AX_IDLE;
        end
      end
      default: n.bus = AX_IDLE;
    endcase

    // Receive shifter, sampled at the falling pin clock, LSB first
    if (!q.ctrl[BIT_RX_EN]) begin
      n.rx_cnt  = 4'h0;
      n.overrun = 1'b0;
    end else if (shift_on && ck_fall && !q.overrun) begin
      n.rsr = {q.dt_level, q.rsr[CHAR_W-1:1]};
      if (q.rx_cnt == 4'(char_len(q.ctrl[BIT_NINTH_EN]) - 4'h1)) begin
        n.rx_cnt = 4'h0;
        rx_push  = 1'b1;
        rx_char  = q.ctrl[BIT_NINTH_EN] ? n.rsr : {1'b0, n.rsr[CHAR_W-1:1]};
      end else begin
        n.rx_cnt = 4'(q.rx_cnt + 4'h1);
      end
    end

    // Receive FIFO; a character into a full FIFO is dropped
    ovr = rx_push && (q.fifo_cnt == FIFO_FULL) && !pop;
    if (ovr) begin
      n.overrun   = 1'b1;
      ev[EV_OVR]  = 1'b1;
    end
    if (pop) begin
      n.rd_ptr = !q.rd_ptr;
    end
    if (rx_push && !ovr) begin
      n.fifo[q.rd_ptr ^ q.fifo_cnt[0]] = rx_char;
      ev[EV_RX] = 1'b1;
    end
    n.fifo_cnt = 2'(q.fifo_cnt + {1'b0, rx_push && !ovr} - {1'b0, pop});

    // Transmit shifter: drive at rising pin clock, advance after falling
    if (shift_on && q.tsr_full) begin
      if (ck_rise) begin
        n.data_out = q.transmit_shift_reg[0];
      end
      if (ck_fall) begin
        n.transmit_shift_reg = {1'b0, q.transmit_shift_reg[CHAR_W-1:1]};
        if (q.tx_cnt == 4'(char_len(q.ctrl[BIT_NINTH_EN]) - 4'h1)) begin
          n.tsr_full = 1'b0;
          n.tx_cnt   = 4'h0;
        end else begin
          n.tx_cnt = 4'(q.tx_cnt + 4'h1);
        end
      end
    end

    // Buffered byte moves into the empty shift register
    if (!q.tsr_full && q.buf_full) begin
      n.transmit_shift_reg      = q.tx_buf;
      n.tsr_full = 1'b1;
      n.buf_full = 1'b0;
      n.tx_flag  = 1'b1;
      ev[EV_TX]  = 1'b1;
    end

    // Transmit data write, ignored while the buffer is still occupied
    if (tx_wr && !q.buf_full) begin
      n.tx_buf   = {q.ctrl[BIT_TX_NINTH], q.w_data[BYTE_W-1:0]};
      n.buf_full = 1'b1;
      n.tx_flag  = 1'b0;
    end

    // Sticky events, a new event outranks a clear in the same cycle
    n.irq_stat = (q.irq_stat & ~w1c) | ev;

    // Port disabled: shifter counts, FIFO level, overrun and transmit state held in reset
    if (!q.ctrl[BIT_PORT_EN]) begin
      n.fifo_cnt = 2'h0;
      n.rd_ptr   = 1'b0;
      n.overrun  = 1'b0;
      n.rsr      = '0;
      n.rx_cnt   = 4'h0;
      n.buf_full = 1'b0;
      n.tsr_full = 1'b0;
      n.tx_cnt   = 4'h0;
      n.tx_flag  = TX_FLAG_RESET;
      n.data_out = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.bus      <= AX_IDLE;
      q.ctrl     <= CTRL_RESET;
      q.irq_mask <= MASK_RESET;
      q.tx_flag  <= TX_FLAG_RESET;
    end else begin
      q <= n;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ninth_len: assert property (rx_push |-> q.rx_cnt == (q.ctrl[BIT_NINTH_EN] ? 4'h8 : 4'h7))
    else $error("character length does not follow ninth-bit enable");
  a_rx_gated: assert property (!q.ctrl[BIT_RX_EN] |=> q.rx_cnt == 4'h0 && !rx_push)
    else $error("receiver active without receive enable");
  a_rx_flag_set: assert property (rx_push && !ovr |=> q.fifo_cnt != 2'h0 && q.irq_stat[EV_RX])
    else $error("completed character did not set receive flag");
  a_ninth_shown: assert property (rx_push && q.fifo_cnt == 2'h0 && !pop
                   |=> q.fifo[q.rd_ptr] == $past(rx_char))
    else $error("head character differs from received word");
  a_pop_level: assert property (pop && !rx_push |=> q.fifo_cnt == $past(q.fifo_cnt) - 2'h1)
    else $error("read did not unload a character");
  a_ovr_clear: assert property (!q.ctrl[BIT_RX_EN] || !q.ctrl[BIT_PORT_EN] |=> !q.overrun)
    else $error("overrun survived its clear");
  a_no_shift: assert property (q.ctrl[BIT_PORT_EN] && !q.ctrl[BIT_SLAVE]
                |=> $stable(q.rsr) && $stable(q.tx_cnt))
    else $error("shifting outside slave mode");
  a_tx_write: assert property (q.ctrl[BIT_PORT_EN] && tx_wr && !q.buf_full
                |=> !q.tx_flag && q.buf_full ##1 q.tsr_full)
    else $error("transmit write did not clear flag");
  a_tx_move: assert property (q.ctrl[BIT_PORT_EN] && q.buf_full && !q.tsr_full
               |=> q.tx_flag && q.tsr_full && !q.buf_full)
    else $error("buffered byte not moved to shift register");
  a_ovr_drop: assert property (ovr |=> q.overrun && q.fifo_cnt == 2'h2 ##1 !rx_push)
    else $error("overrun not flagged or character kept");
  a_wake_sleep: assert property (q.ctrl[BIT_SLEEP] && q.irq_stat[EV_RX] && q.irq_mask[EV_RX]
                  |-> wake)
    else $error("receive flag did not wake in sleep");

endmodule

// ---- tb/sync_master_model.sv ----
// External synchronous master that supplies the serial clock and data
`timescale 1ns/100ps
module sync_master_model (
  input  wire logic serial_data_out,
  output logic      serial_clock_pin,
  output logic      serial_data_in
);
  // ==========================================================================
  // Link idle: clock stands low between frames
  initial begin
    serial_clock_pin = 1'b0;
    serial_data_in   = 1'b1;
  end

  // ==========================================================================
  // Send n bits LSB first, each bit set 40 ns before the rise and changed at the fall
  task automatic send(input logic [8:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in = v[i];
      #40 serial_clock_pin = 1'b1;
      #40 serial_clock_pin = 1'b0;
    end
    #40 serial_data_in = ~serial_data_in; // Released line shows the inverse
  endtask

  // Clock n bits out of the unit, sampled 39 ns after each fall
  task automatic take(input int n, output logic [8:0] v);
    v = 9'h000;
    for (int i = 0; i < n; i++) begin
      #40 serial_clock_pin = 1'b1;
      #40 serial_clock_pin = 1'b0;
      #39 v[i] = serial_data_out;
      #1;
    end
  endtask
endmodule

// ---- tb/sync_serial_rx_tx_sleep_tb_top.sv ----
// Self-checking bench for the synchronous serial unit
`timescale 1ns/100ps
module sync_serial_rx_tx_sleep_tb_top;
  import sync_serial_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sclk, sdin, sdout, sdoe_n, irq, wake;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;

  sync_serial_rx_tx_sleep u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .serial_clock_pin(sclk), .serial_data_in(sdin),
    .serial_data_out(sdout), .serial_data_oe_n(sdoe_n), .irq(irq), .wake(wake));
  sync_master_model u_master (.serial_data_out(sdout), .serial_clock_pin(sclk),
    .serial_data_in(sdin));

  // ==========================================================================
  // Clock, and a ceiling on run length
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      close_out();
    end
  end

  // ==========================================================================
  // Report and verdict
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================================
  // Bus cycles: handshakes judged at the falling edge, released after the rise
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok, b_ok;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= {24'h0, a};
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      last_resp = bresp;
      @(posedge aclk);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
    bready <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic        a_ok, r_ok;
    logic [31:0] d;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= {24'h0, a};
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = arvalid & arready;
      r_ok = rvalid;
      d = rdata;
      last_resp = rresp;
      @(posedge aclk);
      if (a_ok) arvalid <= 1'b0;
    end while (!r_ok);
    rready <= 1'b0;
    chk(what, d & m, e);
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge aclk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rdc("ctrl reset", OFF_CTRL, 32'hffffffff, 32'h0);
    rdc("status reset", OFF_STATUS, 32'h77, 32'h12);
    rdc("mask reset", OFF_IRQ_MASK, 32'hffffffff, 32'h0);
    rdc("irq stat reset", OFF_IRQ_STAT, 32'hffffffff, 32'h0);
    rdc("unmapped data", 8'h18, 32'hffffffff, 32'h0);
    chk("unmapped rd resp", 32'(last_resp), 32'(RESP_SLVERR));
    wr(8'h18, 32'h1);
    chk("unmapped wr resp", 32'(last_resp), 32'(RESP_SLVERR));
    chk("irq idle", 32'(irq), 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_gate();
    logic [7:0] cfg [2] = '{8'h19, 8'h13};
    foreach (cfg[i]) begin
      wr(OFF_CTRL, {24'h0, cfg[i]});
      u_master.send(9'h0a5, 8);
      repeat (10) @(posedge aclk);
      rdc("no char taken", OFF_STATUS, 32'h61, 32'h0);
    end
    wr(OFF_CTRL, 32'h0);
    $display("t_gate done");
  endtask

  task automatic t_rx8();
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'h1b);
    u_master.send(9'h0a5, 8);
    wait_irq();
    chk("rx irq", 32'(irq), 32'h1);
    chk("rx wake", 32'(wake), 32'h1);
    rdc("rx flag", OFF_STATUS, 32'h61, 32'h21);
    rdc("rx byte", OFF_RX_DATA, 32'hffffffff, 32'ha5);
    rdc("rx flag clear", OFF_STATUS, 32'h61, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    chk("masked irq", 32'(irq), 32'h0);
    rdc("sticky event", OFF_IRQ_STAT, 32'h7, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    rdc("event cleared", OFF_IRQ_STAT, 32'h7, 32'h0);
    $display("t_rx8 done");
  endtask

  task automatic t_rx9();
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL, 32'h1f);
    u_master.send(9'h13c, 9);
    u_master.send(9'h0c3, 9);
    repeat (8) @(posedge aclk);
    rdc("two held", OFF_STATUS, 32'h68, 32'h48);
    rdc("oldest byte", OFF_RX_DATA, 32'hffffffff, 32'h3c);
    rdc("ninth bit low", OFF_STATUS, 32'h68, 32'h20);
    rdc("second byte", OFF_RX_DATA, 32'hffffffff, 32'hc3);
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_CTRL, 32'h0);
    $display("t_rx9 done");
  endtask

  task automatic t_ovr();
    wr(OFF_IRQ_MASK, 32'h4);
    wr(OFF_CTRL, 32'h1b);
    for (int i = 1; i < 5; i++) u_master.send(9'(8'h11 * i), 8);
    repeat (8) @(posedge aclk);
    chk("overrun irq", 32'(irq), 32'h1);
    rdc("overrun set", OFF_STATUS, 32'h64, 32'h44);
    rdc("first kept", OFF_RX_DATA, 32'hffffffff, 32'h11);
    rdc("second kept", OFF_RX_DATA, 32'hffffffff, 32'h22);
    rdc("reception halted", OFF_STATUS, 32'h61, 32'h0);
    wr(OFF_CTRL, 32'h19);
    rdc("overrun cleared", OFF_STATUS, 32'h4, 32'h0);
    wr(OFF_IRQ_STAT, 32'h7);
    $display("t_ovr done");
  endtask

  task automatic t_tx();
    logic [8:0] v;
    wr(OFF_IRQ_MASK, 32'h2);
    wr(OFF_TX_DATA, 32'h5a);
    wr(OFF_TX_DATA, 32'hc3);
    rdc("both loaded", OFF_STATUS, 32'h12, 32'h0);
    wr(OFF_IRQ_STAT, 32'h2);
    chk("pin driven", 32'(sdoe_n), 32'h0);
    u_master.take(8, v);
    chk("first out", 32'(v), 32'h5a);
    wait_irq();
    chk("tx irq", 32'(irq), 32'h1);
    chk("tx wake", 32'(wake), 32'h1);
    rdc("tx flag set", OFF_STATUS, 32'h2, 32'h2);
    u_master.take(8, v);
    chk("second out", 32'(v), 32'hc3);
    wr(OFF_IRQ_STAT, 32'h2);
    wr(OFF_CTRL, 32'h0);
    chk("pin released", 32'(sdoe_n), 32'h1);
    $display("t_tx done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gate();
    t_rx8();
    t_rx9();
    t_ovr();
    t_tx();
    close_out();
  end
endmodule
